/* File: rtl/fault_consts.svh */
// Constants of the general and disabled floating-point fault syndrome block
// Assumes inclusion by the design module only
//
// Overview of operation
// - General faults go to vector 0x5400
// - Illegal operation codes 0; never legacy
// - Privileged operation 1, register 2; never legacy
// - Reserved/unimplemented code 3; stack flag marks source
// - Disabled transition codes 4; saved set bit
// - Dependency violation codes 8; never legacy
// - Non-access kind goes to code 3:0 for privileged, reserved and native transition faults
// - Legacy general faults zero all side flags except the read and write bits
// - Return to reserved template keeps restart slot
// - Long-immediate bundle at slot 2 faults
// - Same predicate twice faults, some ignore qualifier
// - Stack pointer access with mode non-zero faults
// - Stack reload with frame or overflow faults
// - Predicated legacy branch, or one with store pointer differing from backing store pointer, faults
// - Promotion below current privilege faults
// - Collection on: interruption access, inserts fault
// - Illegal/dependency syndrome holds code, slot, nested
// - Disabled register bank goes to 0x5500
// - Low bank disabled faults every legacy FP
// - High bank disabled faults first legacy instruction
// - Legacy high and low together report high
// - Code bit 0 low, bit 1 high bank
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

// ----------------------------------------------------------------------
// Vectors and cause codes
// ----------------------------------------------------------------------
`define VEC_GENERAL       16'h5400
`define VEC_FP_DISABLED   16'h5500
`define CODE_ILLEGAL_OP   4'h0
`define CODE_PRIV_OP      4'h1
`define CODE_PRIV_REG     4'h2
`define CODE_RESERVED     4'h3
`define CODE_TRANSITION   4'h4
`define CODE_DEPENDENCY   4'h8
`define SLOT_LONG_IMM     2'h2

// ----------------------------------------------------------------------
// Syndrome field positions
// ----------------------------------------------------------------------
`define SYN_CODE_HI       7
`define SYN_CODE_MID      4
`define SYN_CODE_LO       0
`define SYN_FP_LOW        0
`define SYN_FP_HIGH       1
`define SYN_W             33
`define SYN_R             34
`define SYN_NA            35
`define SYN_SP            36
`define SYN_RS            37
`define SYN_IR            38
`define SYN_NI            39
`define SYN_EI            41
`define SYN_ED            43

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define OFS_SYN_LO        12'h000
`define OFS_SYN_HI        12'h004
`define OFS_STATUS        12'h008
`define OFS_CONTROL       12'h00c
`define RST_CONTROL       32'h0000_0001
`define RST_SYNDROME      64'h0000_0000_0000_0000

`endif

/* File: rtl/fault_pkg.sv */
// Types of the fault syndrome block
// Assumes the pipeline reports at most one instruction per cycle
package fault_pkg;

	// ------------------------------------------------------------------
	// Fault report from the pipeline
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic       legacy;
		logic [1:0] slot;
		logic [1:0] restart_slot;
		logic       nested;
		logic       probe_kind;
		logic       deferral;
		logic       incomplete;
		logic       rd;
		logic       wr;
		logic       nonaccess;
		logic [3:0] nonaccess_kind;
		logic       misc_illegal;
		logic       rfi_reserved_tmpl;
		logic       long_imm_tmpl;
		logic       dual_pred_same;
		logic       pred_uncond_class;
		logic       qual_pred;
		logic       stack_ptr_access;
		logic       stack_reload;
		logic       reload_count_nz;
		logic       reload_overflow;
		logic       branch_to_legacy;
		logic       branch_predicated;
		logic       priv_promotion;
		logic       intr_reg_access;
		logic       tlb_insert;
		logic       priv_op;
		logic       priv_reg;
		logic       reserved_field;
		logic       unimpl_addr;
		logic       unimpl_by_stack;
		logic       transition;
		logic       dependency;
		logic       fp_insn;
		logic       fp_low_ref;
		logic       fp_high_ref;
		logic       first_after_entry;
	} fault_report_s;

	// ------------------------------------------------------------------
	// Processor status seen by the checks
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       transition_disable_bit;
		logic       low_bank_disable_bit;
		logic       high_bank_disable_bit;
		logic       interruption_collection_bit;
		logic [1:0] current_privilege_level;
		logic [1:0] previous_privilege_level;
		logic [1:0] stack_engine_config_mode;
		logic [6:0] current_frame_size;
	} core_status_s;

endpackage

/* File: rtl/general_and_fp_fault_syndrome.sv */
// Fault classification, precedence and syndrome capture for the general
// exception and disabled floating-point register vectors
// Assumes the pipeline drives report and status synchronously to clock
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fault_consts.svh"

module general_and_fp_fault_syndrome
	import fault_pkg::*;
#(
	parameter int PTR_W = 64
)
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire fault_report_s       report,
	input  wire core_status_s        status,
	input  wire logic [PTR_W-1:0]    backing_store_store_pointer,
	input  wire logic [PTR_W-1:0]    backing_store_pointer,
	output logic                     fault_taken,
	output logic [15:0]              vector_offset,
	output logic [63:0]              fault_syndrome_reg,
	output logic [1:0]               saved_restart_slot,
	output logic                     saved_instruction_set_bit,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic                hready,
	input  wire logic [31:0]         hwdata,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata
);

	// ------------------------------------------------------------------
	// Syndrome assembly
	// ------------------------------------------------------------------
	function automatic logic [63:0] build_syn(
		input logic [3:0] c74,
		input logic [3:0] c30,
		input logic [1:0] ei,
		input logic       ni,
		input logic       na,
		input logic       sp,
		input logic       rs,
		input logic       ir,
		input logic       r,
		input logic       w
	);
		logic [63:0] s;
		s = 64'h0;
		s[`SYN_CODE_HI:`SYN_CODE_MID] = c74;
		s[`SYN_CODE_MID-1:`SYN_CODE_LO] = c30;
		s[`SYN_EI+1:`SYN_EI] = ei;
		s[`SYN_NI] = ni;
		s[`SYN_NA] = na;
		s[`SYN_SP] = sp;
		s[`SYN_RS] = rs;
		s[`SYN_IR] = ir;
		s[`SYN_R] = r;
		s[`SYN_W] = w;
		return s;
	endfunction

	// ------------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------------
	logic        native;
	logic        tmpl_fault;
	logic        dual_fault;
	logic        stack_fault;
	logic        reload_fault;
	logic        branch_fault;
	logic        promo_fault;
	logic        collect_fault;
	logic        illegal_op;
	logic        priv_op;
	logic        priv_reg;
	logic        reserved;
	logic        transition;
	logic        dependency;
	logic        fp_low;
	logic        fp_high;
	logic        any_fault;
	logic        take;
	logic        capture_en;

	assign native = !report.legacy;
	assign tmpl_fault = report.rfi_reserved_tmpl
		|| (report.long_imm_tmpl && report.restart_slot == `SLOT_LONG_IMM);
	assign dual_fault = report.dual_pred_same
		&& (report.qual_pred || report.pred_uncond_class);
	assign stack_fault = (report.stack_ptr_access || report.stack_reload)
		&& status.stack_engine_config_mode != 2'h0;
	assign reload_fault = report.stack_reload && (report.reload_overflow
		|| (status.current_frame_size != 7'h0 && report.reload_count_nz));
	assign branch_fault = report.branch_to_legacy && (report.branch_predicated
		|| backing_store_store_pointer != backing_store_pointer);
	assign promo_fault = report.priv_promotion
		&& status.previous_privilege_level < status.current_privilege_level;
	assign collect_fault = status.interruption_collection_bit
		&& (report.intr_reg_access || report.tlb_insert);
	assign illegal_op = native && (report.misc_illegal || tmpl_fault || dual_fault
		|| stack_fault || reload_fault || branch_fault || promo_fault
		|| collect_fault);
	assign priv_op = native && report.priv_op;
	assign priv_reg = native && report.priv_reg;
	assign reserved = native && (report.reserved_field || report.unimpl_addr);
	assign transition = report.transition && status.transition_disable_bit;
	assign dependency = native && report.dependency;
	assign fp_low = status.low_bank_disable_bit
		&& (report.legacy ? report.fp_insn : report.fp_low_ref);
	assign fp_high = status.high_bank_disable_bit
		&& (report.legacy ? report.first_after_entry : report.fp_high_ref);
	assign any_fault = illegal_op || priv_op || priv_reg || reserved || transition
		|| dependency || fp_low || fp_high;
	assign take = ce && report.valid && capture_en && any_fault;

	// ------------------------------------------------------------------
	// Precedence and syndrome selection
	// ------------------------------------------------------------------
	logic [63:0] syn_d;
	logic [15:0] vec_d;
	logic [1:0]  ri_d;
	logic [3:0]  c30;
	logic [1:0]  ei;
	logic        ni;

	always_comb
	begin
		c30 = report.nonaccess ? report.nonaccess_kind : 4'h0;
		ei = native ? report.slot : 2'h0;
		ni = native && report.nested;
		ri_d = report.slot;
		vec_d = `VEC_GENERAL;
		syn_d = `RST_SYNDROME;
		if (illegal_op)
		begin
			if (tmpl_fault)
			begin
				ri_d = report.restart_slot;
				ei = report.restart_slot;
			end
			syn_d = build_syn(`CODE_ILLEGAL_OP, 4'h0, ei, ni, 1'b0, 1'b0, 1'b0, 1'b0,
				1'b0, 1'b0);
		end
		else if (priv_op || priv_reg || reserved)
		begin
			syn_d = build_syn(priv_op ? `CODE_PRIV_OP : priv_reg ? `CODE_PRIV_REG
				: `CODE_RESERVED, c30, ei, ni, report.probe_kind, 1'b0,
				report.unimpl_addr && report.unimpl_by_stack, report.incomplete,
				report.rd, report.wr);
		end
		else if (transition)
		begin
			syn_d = build_syn(`CODE_TRANSITION, native ? c30 : 4'h0, ei, ni,
				native && report.probe_kind, 1'b0, 1'b0, native && report.incomplete,
				report.rd, report.wr);
		end
		else if (dependency)
		begin
			syn_d = build_syn(`CODE_DEPENDENCY, 4'h0, ei, ni, 1'b0, 1'b0, 1'b0, 1'b0,
				1'b0, 1'b0);
		end
		else
		begin
			vec_d = `VEC_FP_DISABLED;
			syn_d = build_syn(4'h0, 4'h0, ei, ni, 1'b0,
				native && report.deferral, 1'b0, 1'b0, native && report.rd,
				native && report.wr);
			syn_d[`SYN_FP_HIGH] = fp_high;
			syn_d[`SYN_FP_LOW] = fp_low && !(report.legacy && fp_high);
		end
	end

	// ------------------------------------------------------------------
	// Interruption state
	// ------------------------------------------------------------------
	logic        taken_q;
	logic [15:0] vec_q;
	logic [63:0] syn_q;
	logic [1:0]  ri_q;
	logic        is_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			taken_q <= 1'b0;
		else if (ce)
			taken_q <= take;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			vec_q <= 16'h0;
			syn_q <= `RST_SYNDROME;
			ri_q  <= 2'h0;
			is_q  <= 1'b0;
		end
		else if (take)
		begin
			vec_q <= vec_d;
			syn_q <= syn_d;
			ri_q  <= ri_d;
			is_q  <= report.legacy;
		end
	end

	assign fault_taken = taken_q;
	assign vector_offset = vec_q;
	assign fault_syndrome_reg = syn_q;
	assign saved_restart_slot = ri_q;
	assign saved_instruction_set_bit = is_q;

	// ------------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------------
	logic [31:0] control_q;
	logic [31:0] rdata_q;
	logic        wr_pend_q;
	logic [11:0] wr_addr_q;
	logic        addr_ok;
	logic [31:0] rd_mux;

	assign capture_en = control_q[0];
	assign addr_ok = hsel && hready && htrans[1];

	always_comb
	begin
		unique case (haddr[11:0])
			`OFS_SYN_LO:  rd_mux = syn_q[31:0];
			`OFS_SYN_HI:  rd_mux = syn_q[63:32];
			`OFS_STATUS:  rd_mux = {13'h0, is_q, ri_q, vec_q};
			`OFS_CONTROL: rd_mux = control_q;
			default:      rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h0;
			rdata_q   <= 32'h0;
		end
		else if (ce)
		begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[11:0];
			if (addr_ok && !hwrite)
				rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			control_q <= `RST_CONTROL;
		else if (ce && wr_pend_q && wr_addr_q == `OFS_CONTROL)
			control_q <= {31'h0, hwdata[0]};
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	general_vector_a: assert property (@(posedge clock) disable iff (rst)
		(take && (illegal_op || priv_op || dependency)) |=> vector_offset == `VEC_GENERAL)
		else $error("general fault not on general vector");

	illegal_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && illegal_op) |=> (fault_taken && fault_syndrome_reg[38:0] == 39'h0
		&& fault_syndrome_reg[63:43] == 21'h0 && !fault_syndrome_reg[40]))
		else $error("illegal operation syndrome carries extra fields");

	legacy_never_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy) |=> (vector_offset == `VEC_FP_DISABLED
		|| fault_syndrome_reg[7:4] == `CODE_TRANSITION))
		else $error("legacy instruction raised native-only fault");

	legacy_flags_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy && vec_d == `VEC_GENERAL)
		|=> fault_syndrome_reg[43:35] == 9'h0)
		else $error("legacy general fault left flags set");

	long_slot_a: assert property (@(posedge clock) disable iff (rst)
		(take && illegal_op && report.long_imm_tmpl && report.restart_slot == 2'h2)
		|=> (saved_restart_slot == 2'h2 && fault_syndrome_reg[42:41] == 2'h2))
		else $error("long-immediate slot not recorded as 2");

	fp_precedence_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy && fp_high && vec_d == `VEC_FP_DISABLED)
		|=> fault_syndrome_reg[1:0] == 2'h2)
		else $error("low-bank fault reported beside high-bank fault");

	transition_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && transition && !illegal_op && !priv_op && !priv_reg && !reserved)
		|=> (fault_syndrome_reg[7:4] == 4'h4 && saved_instruction_set_bit
		== $past(report.legacy)))
		else $error("transition fault code or set bit wrong");

	fp_vector_a: assert property (@(posedge clock) disable iff (rst)
		(take && !illegal_op && !priv_op && !priv_reg && !reserved && !transition
		&& !dependency) |=> vector_offset == `VEC_FP_DISABLED)
		else $error("disabled bank fault on wrong vector");

	hold_state_a: assert property (@(posedge clock) disable iff (rst)
		!take |=> $stable(fault_syndrome_reg))
		else $error("syndrome changed without a fault");

	priv_op_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && priv_op && !illegal_op)
		|=> fault_syndrome_reg[7:4] == `CODE_PRIV_OP)
		else $error("privileged operation code wrong");

	priv_reg_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && priv_reg && !illegal_op && !priv_op)
		|=> fault_syndrome_reg[7:4] == `CODE_PRIV_REG)
		else $error("privileged register code wrong");

	reserved_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && reserved && !illegal_op && !priv_op && !priv_reg)
		|=> fault_syndrome_reg[7:4] == `CODE_RESERVED)
		else $error("reserved fault code wrong");

	stack_source_a: assert property (@(posedge clock) disable iff (rst)
		(take && reserved && report.unimpl_addr && !illegal_op && !priv_op
		&& !priv_reg)
		|=> fault_syndrome_reg[`SYN_RS] == $past(report.unimpl_by_stack))
		else $error("stack flag does not mark the source");

	dependency_code_a: assert property (@(posedge clock) disable iff (rst)
		(take && dependency && !illegal_op && !priv_op && !priv_reg && !reserved
		&& !transition) |=> fault_syndrome_reg[7:0] == {`CODE_DEPENDENCY, 4'h0})
		else $error("dependency fault code wrong");

	nonaccess_kind_a: assert property (@(posedge clock) disable iff (rst)
		(take && !illegal_op && (priv_op || priv_reg || reserved) && report.nonaccess)
		|=> fault_syndrome_reg[3:0] == $past(report.nonaccess_kind))
		else $error("non-access kind not recorded");

	reserved_tmpl_a: assert property (@(posedge clock) disable iff (rst)
		(take && illegal_op && report.rfi_reserved_tmpl)
		|=> (saved_restart_slot == $past(report.restart_slot)
		&& fault_syndrome_reg[42:41] == saved_restart_slot))
		else $error("reserved template slot not kept");

	taken_pulse_a: assert property (@(posedge clock) disable iff (rst)
		(ce && !take) |=> !fault_taken)
		else $error("fault taken without a fault");

	low_bank_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy && fp_low && !fp_high && !transition)
		|=> (vector_offset == `VEC_FP_DISABLED && fault_syndrome_reg[1:0] == 2'h1))
		else $error("low-bank fault not reported");

	high_bank_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy && fp_high && !transition)
		|=> (vector_offset == `VEC_FP_DISABLED && fault_syndrome_reg[`SYN_FP_HIGH]))
		else $error("high-bank fault not reported");

	legacy_fp_zero_a: assert property (@(posedge clock) disable iff (rst)
		(take && report.legacy && vec_d == `VEC_FP_DISABLED)
		|=> fault_syndrome_reg[63:2] == 62'h0)
		else $error("legacy bank fault left flags set");

endmodule
`default_nettype wire

/* File: sim/fault_pipe_model.sv */
// Pipeline model: presents one fault report at a time with status bits
// Assumes the bench calls issue from its main sequence on the shared clock
`timescale 1ns/1ps
`default_nettype none

module fault_pipe_model
	import fault_pkg::*;
#(
	parameter int PTR_W = 16
)
(
	input  wire logic        clock,
	output var fault_report_s report,
	output var core_status_s  status,
	output logic [PTR_W-1:0] backing_store_store_pointer,
	output logic [PTR_W-1:0] backing_store_pointer
);
	initial
	begin
		report = '0;
		status = '0;
		backing_store_store_pointer = '0;
		backing_store_pointer = '0;
	end

	// --------------------------------------------------------------
	// One report for one cycle, then flipped fields with valid low
	// --------------------------------------------------------------
	task automatic issue(input fault_report_s r, input core_status_s s, input logic d);
		fault_report_s idle;
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge clock);
		report <= r;
		status <= s;
		backing_store_pointer <= PTR_W'(16'h0240);
		backing_store_store_pointer <= d ? PTR_W'(16'h02c0) : PTR_W'(16'h0240);
		@(posedge clock);
		report <= idle;
	endtask
endmodule

`default_nettype wire

/* File: sim/general_and_fp_fault_syndrome_tb.sv */
// Self-checking bench for the fault syndrome block
// Assumes the pipeline model and the block share one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none

module general_and_fp_fault_syndrome_tb
	import fault_pkg::*;
;
	localparam int PW = 16;
	logic          clock = 1'b0;
	logic          rst = 1'b1;
	logic          ce = 1'b1;
	fault_report_s report;
	core_status_s  status;
	core_status_s  s0 = '0;
	logic [PW-1:0] backing_store_store_pointer;
	logic [PW-1:0] backing_store_pointer;
	logic          fault_taken;
	logic [15:0]   vector_offset;
	logic [63:0]   fault_syndrome_reg;
	logic [1:0]    saved_restart_slot;
	logic          saved_instruction_set_bit;
	logic          hsel = 1'b0;
	logic [31:0]   haddr = '0;
	logic [1:0]    htrans = '0;
	logic          hwrite = 1'b0;
	logic [2:0]    hsize = '0;
	logic [31:0]   hwdata = '0;
	logic          hreadyout;
	logic          hresp;
	logic [31:0]   hrdata;
	int            err_total = 0;
	int            total_checks = 0;

	always #50 clock = ~clock;

	fault_pipe_model #(.PTR_W(PW)) i_fault_pipe_model (
		.clock, .report, .status, .backing_store_store_pointer, .backing_store_pointer);

	general_and_fp_fault_syndrome #(.PTR_W(PW)) i_general_and_fp_fault_syndrome (
		.clock, .rst, .ce, .report, .status, .backing_store_store_pointer,
		.backing_store_pointer, .fault_taken, .vector_offset, .fault_syndrome_reg,
		.saved_restart_slot, .saved_instruction_set_bit, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata);

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [63:0] gen(input logic [3:0] c74, input logic [3:0] c30,
		input logic [1:0] ei, input logic ni);
		return {20'h0, 1'b0, ei, 1'b0, ni, 7'h0, 24'h0, c74, c30};
	endfunction

	function automatic fault_report_s side(input logic [1:0] slot, input logic rw);
		return '{valid:1'b1, slot:slot, nested:1'b1, probe_kind:1'b1, deferral:1'b1,
			incomplete:1'b1, rd:rw, wr:rw, default:'0};
	endfunction

	task automatic run(input fault_report_s r, input core_status_s s, input logic d,
		input logic hit, input logic [15:0] vec, input logic [63:0] syn);
		logic [63:0] prev;
		prev = fault_syndrome_reg;
		i_fault_pipe_model.issue(r, s, d);
		#1;
		check("fault_taken", 64'(fault_taken), 64'(hit));
		if (hit)
		begin
			check("vector_offset", 64'(vector_offset), 64'(vec));
			check("syndrome", fault_syndrome_reg, syn);
		end
		else
			check("syndrome_kept", fault_syndrome_reg, prev);
	endtask

	task automatic gf(input fault_report_s r, input core_status_s s, input logic [63:0] syn);
		run(r, s, 1'b0, 1'b1, 16'h5400, syn);
	endtask

	task automatic nf(input fault_report_s r, input core_status_s s);
		run(r, s, 1'b0, 1'b0, 16'h0, 64'h0);
	endtask

	task automatic il(input fault_report_s r, input core_status_s s, input logic hit,
		input logic d = 1'b0);
		run(r, s, d, hit, 16'h5400, 64'h0);
	endtask

	task automatic fp(input fault_report_s r, input core_status_s s, input logic [3:0] c);
		run(r, s, 1'b0, 1'b1, 16'h5500, {60'h0, c});
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		rd = hrdata;
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		check("syndrome", fault_syndrome_reg, 64'h0);
		ahb(1'b0, 32'hc, 32'h0, d);
		check("control", 64'(d), 64'h1);
		check("hresp", 64'(hresp), 64'h0);
	endtask

	task automatic t_general();
		fault_report_s r;
		r = side(2'h1, 1'b1);
		r.nonaccess = 1'b1;
		r.nonaccess_kind = 4'h5;
		r.misc_illegal = 1'b1;
		gf(r, s0, gen(4'h0, 4'h0, 2'h1, 1'b1));
		r.legacy = 1'b1;
		nf(r, s0);
		r = side(2'h2, 1'b1);
		r.dependency = 1'b1;
		gf(r, s0, gen(4'h8, 4'h0, 2'h2, 1'b1));
		r.legacy = 1'b1;
		nf(r, s0);
		r = '{valid:1'b1, slot:2'h2, nonaccess:1'b1, nonaccess_kind:4'h5, priv_op:1'b1, default:'0};
		gf(r, s0, gen(4'h1, 4'h5, 2'h2, 1'b0));
		r.legacy = 1'b1;
		nf(r, s0);
		gf('{valid:1'b1, priv_reg:1'b1, default:'0}, s0, gen(4'h2, 4'h0, 2'h0, 1'b0));
		gf('{valid:1'b1, reserved_field:1'b1, default:'0}, s0, gen(4'h3, 4'h0, 2'h0, 1'b0));
		r = '{valid:1'b1, unimpl_addr:1'b1, unimpl_by_stack:1'b1, default:'0};
		gf(r, s0, gen(4'h3, 4'h0, 2'h0, 1'b0) | 64'h20_0000_0000);
		r.unimpl_by_stack = 1'b0;
		gf(r, s0, gen(4'h3, 4'h0, 2'h0, 1'b0));
	endtask

	task automatic t_transition();
		fault_report_s r;
		core_status_s  s;
		s = '{transition_disable_bit:1'b1, default:'0};
		r = side(2'h1, 1'b0);
		r.legacy = 1'b1;
		r.transition = 1'b1;
		gf(r, s, gen(4'h4, 4'h0, 2'h0, 1'b0));
		check("is_bit", 64'(saved_instruction_set_bit), 64'h1);
		r = '{valid:1'b1, transition:1'b1, default:'0};
		gf(r, s, gen(4'h4, 4'h0, 2'h0, 1'b0));
		check("is_bit", 64'(saved_instruction_set_bit), 64'h0);
		nf(r, s0);
	endtask

	task automatic t_template();
		fault_report_s r;
		r = '{valid:1'b1, restart_slot:2'h1, rfi_reserved_tmpl:1'b1, default:'0};
		gf(r, s0, gen(4'h0, 4'h0, 2'h1, 1'b0));
		check("restart_slot", 64'(saved_restart_slot), 64'h1);
		r = '{valid:1'b1, restart_slot:2'h2, long_imm_tmpl:1'b1, default:'0};
		gf(r, s0, gen(4'h0, 4'h0, 2'h2, 1'b0));
		check("restart_slot", 64'(saved_restart_slot), 64'h2);
		r.restart_slot = 2'h1;
		nf(r, s0);
	endtask

	task automatic t_cond();
		core_status_s sm, sf, sp, se, sc;
		sm = '{stack_engine_config_mode:2'h1, default:'0};
		sf = '{current_frame_size:7'h4, default:'0};
		sp = '{previous_privilege_level:2'h0, current_privilege_level:2'h2, default:'0};
		se = '{previous_privilege_level:2'h2, current_privilege_level:2'h2, default:'0};
		sc = '{interruption_collection_bit:1'b1, default:'0};
		il('{valid:1'b1, dual_pred_same:1'b1, pred_uncond_class:1'b1, default:'0}, s0, 1'b1);
		il('{valid:1'b1, dual_pred_same:1'b1, qual_pred:1'b1, default:'0}, s0, 1'b1);
		il('{valid:1'b1, dual_pred_same:1'b1, default:'0}, s0, 1'b0);
		il('{valid:1'b1, stack_ptr_access:1'b1, default:'0}, sm, 1'b1);
		il('{valid:1'b1, stack_ptr_access:1'b1, default:'0}, s0, 1'b0);
		il('{valid:1'b1, stack_reload:1'b1, default:'0}, sm, 1'b1);
		il('{valid:1'b1, stack_reload:1'b1, reload_count_nz:1'b1, default:'0}, sf, 1'b1);
		il('{valid:1'b1, stack_reload:1'b1, reload_count_nz:1'b1, default:'0}, s0, 1'b0);
		il('{valid:1'b1, stack_reload:1'b1, reload_overflow:1'b1, default:'0}, s0, 1'b1);
		il('{valid:1'b1, branch_to_legacy:1'b1, branch_predicated:1'b1, default:'0}, s0, 1'b1);
		il('{valid:1'b1, branch_to_legacy:1'b1, default:'0}, s0, 1'b1, 1'b1);
		il('{valid:1'b1, branch_to_legacy:1'b1, default:'0}, s0, 1'b0);
		il('{valid:1'b1, priv_promotion:1'b1, default:'0}, sp, 1'b1);
		il('{valid:1'b1, priv_promotion:1'b1, default:'0}, se, 1'b0);
		il('{valid:1'b1, intr_reg_access:1'b1, default:'0}, sc, 1'b1);
		il('{valid:1'b1, intr_reg_access:1'b1, default:'0}, s0, 1'b0);
		il('{valid:1'b1, tlb_insert:1'b1, default:'0}, sc, 1'b1);
	endtask

	task automatic t_fp();
		fault_report_s r;
		core_status_s  sl, sb;
		sl = '{low_bank_disable_bit:1'b1, default:'0};
		sb = '{low_bank_disable_bit:1'b1, high_bank_disable_bit:1'b1, default:'0};
		fp('{valid:1'b1, fp_low_ref:1'b1, default:'0}, sl, 4'h1);
		fp('{valid:1'b1, legacy:1'b1, fp_insn:1'b1, default:'0}, sl, 4'h1);
		nf('{valid:1'b1, legacy:1'b1, fp_insn:1'b1, default:'0}, s0);
		r = side(2'h2, 1'b1);
		r.legacy = 1'b1;
		r.fp_insn = 1'b1;
		r.first_after_entry = 1'b1;
		fp(r, sb, 4'h2);
		nf('{valid:1'b1, legacy:1'b1, default:'0}, sb);
		fp('{valid:1'b1, fp_low_ref:1'b1, fp_high_ref:1'b1, default:'0}, sb, 4'h3);
		nf('{valid:1'b1, fp_high_ref:1'b1, default:'0}, sl);
	endtask

	task automatic t_bus();
		logic [31:0] d;
		gf('{valid:1'b1, slot:2'h2, priv_reg:1'b1, default:'0}, s0, gen(4'h2, 4'h0, 2'h2, 1'b0));
		ahb(1'b0, 32'h0, 32'h0, d);
		check("syn_lo", 64'(d), 64'h20);
		ahb(1'b0, 32'h4, 32'h0, d);
		check("syn_hi", 64'(d), 64'h400);
		ahb(1'b0, 32'h8, 32'h0, d);
		check("status", 64'(d), 64'h0002_5400);
		ahb(1'b1, 32'h0, 32'hffff_ffff, d);
		ahb(1'b0, 32'h0, 32'h0, d);
		check("syn_ro", 64'(d), 64'h20);
		ahb(1'b0, 32'h10, 32'h0, d);
		check("unmapped", 64'(d), 64'h0);
		ahb(1'b1, 32'hc, 32'h0, d);
		nf('{valid:1'b1, misc_illegal:1'b1, default:'0}, s0);
		ahb(1'b0, 32'hc, 32'h0, d);
		check("control", 64'(d), 64'h0);
		ahb(1'b1, 32'hc, 32'h1, d);
		ce <= 1'b0;
		nf('{valid:1'b1, misc_illegal:1'b1, default:'0}, s0);
		@(posedge clock);
		ce <= 1'b1;
		il('{valid:1'b1, misc_illegal:1'b1, default:'0}, s0, 1'b1);
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_general();
		t_transition();
		t_template();
		t_cond();
		t_fp();
		t_bus();
		print_verdict();
	end

	initial
	begin
		#(3000 * 100);
		err_total++;
		print_verdict();
	end
endmodule

`default_nettype wire
